// *** rtl/redriver_config_mode_loader.sv ***
`include "redriver_cfg_params.svh"
`default_nettype none
module redriver_config_mode_loader #(
	parameter int NUM_CH       = `NUM_CH,
	parameter int IW           = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
	parameter int T_EEPROM_CYC = $rtoi(`T_EEPROM_MS * `CLK_FREQ_KHZ),
	parameter int T_POR_CYC    = `T_POR_MS * `CLK_FREQ_KHZ
) (
	input  wire logic                    CLK_SYS,
	input  wire logic                    RESETN,
	input  wire logic                    CE,
	input  wire logic [1:0]              MODE_STRAP,
	input  wire logic [`EQ_W-1:0]        STRAP_EQ,
	input  wire logic [`GAIN_W-1:0]      STRAP_GAIN,
	input  wire logic                    READ_EN_N,
	input  wire logic                    SCL_I,
	output logic                         SCL_O,
	output logic                         SCL_OE,
	input  wire logic                    SDA_I,
	output logic                         SDA_O,
	output logic                         SDA_OE,
	input  wire logic                    SEC_WR_EN,
	input  wire logic [IW-1:0]           SEC_ADDR,
	input  wire logic [`CFG_W-1:0]       SEC_WDATA,
	output logic [`CFG_W-1:0]            SEC_RDATA,
	output logic                         SEC_READY,
	output logic [NUM_CH*`EQ_W-1:0]      CH_EQ,
	output logic [NUM_CH*`GAIN_W-1:0]    CH_GAIN,
	output logic                         CONFIG_LOAD_COMPLETE_N,
	output logic                         EEPROM_LOAD_FAIL
);
	localparam int PW = $clog2(T_POR_CYC + 1);
	localparam int TW = $clog2(T_EEPROM_CYC + 1);

	redriver_cfg_pkg::cfg_mode_t    mode_q;
	redriver_cfg_pkg::fetch_state_t fetch_q;
	logic                mode_valid_q;
	logic [PW-1:0]       por_cnt_q;
	logic                por_done_q;
	logic [TW-1:0]       tmo_q;
	logic                done_n_q;
	logic [`CFG_W-1:0]   cfg_q [NUM_CH];
	logic [`CFG_W-1:0]   rdata_q;
	logic [NUM_CH*`EQ_W-1:0]   eq_q;
	logic [NUM_CH*`GAIN_W-1:0] gain_q;
	logic                is_pin;
	logic                is_eeprom;
	logic                sec_mode;
	logic                sec_wr_ok;
	logic                fetch_start;
	logic                fetch_abort;
	logic                byte_valid;
	logic [IW-1:0]       byte_idx;
	logic [7:0]          byte_data;
	logic                prim_done;

	function automatic logic ch_hit(input logic [IW-1:0] idx, input int ch);
		ch_hit = (int'(idx) == ch);
	endfunction : ch_hit

	assign is_pin      = mode_valid_q && mode_q == redriver_cfg_pkg::MODE_PIN;
	assign is_eeprom   = mode_valid_q && mode_q == redriver_cfg_pkg::MODE_EEPROM;
	assign sec_mode    = mode_valid_q && !is_pin;
	assign SEC_READY   = por_done_q && sec_mode;
	assign sec_wr_ok   = SEC_WR_EN && SEC_READY && (int'(SEC_ADDR) < NUM_CH);
	assign fetch_start = fetch_q == redriver_cfg_pkg::F_IDLE && is_eeprom && !READ_EN_N;
	assign fetch_abort = fetch_q == redriver_cfg_pkg::F_RUN && !prim_done
	                     && tmo_q == TW'(T_EEPROM_CYC - 1);

	assign SCL_O                  = 1'b0;
	assign SDA_O                  = 1'b0;
	assign SEC_RDATA              = rdata_q;
	assign CH_EQ                  = eq_q;
	assign CH_GAIN                = gain_q;
	assign CONFIG_LOAD_COMPLETE_N = done_n_q;
	assign EEPROM_LOAD_FAIL       = fetch_q == redriver_cfg_pkg::F_FAIL;

	////////////////////////////////////////////////////////////////////////////
	// Mode strap is caught once, on the first enabled edge after reset
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			mode_valid_q <= 1'b0;
			mode_q       <= redriver_cfg_pkg::MODE_PIN;
		end else if (CE && !mode_valid_q) begin
			mode_valid_q <= 1'b1;
			mode_q       <= redriver_cfg_pkg::cfg_mode_t'(MODE_STRAP);
		end
	end

	// Secondary access stays closed until the power-on delay has run out
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			por_cnt_q  <= '0;
			por_done_q <= 1'b0;
		end else if (CE && !por_done_q) begin
			por_cnt_q  <= por_cnt_q + PW'(1);
			por_done_q <= por_cnt_q == PW'(T_POR_CYC - 1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// EEPROM load control and its time limit
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			fetch_q <= redriver_cfg_pkg::F_IDLE;
			tmo_q   <= '0;
		end else if (CE) begin
			case (fetch_q)
				redriver_cfg_pkg::F_IDLE: begin
					tmo_q <= '0;
					if (fetch_start)
						fetch_q <= redriver_cfg_pkg::F_RUN;
				end
				redriver_cfg_pkg::F_RUN: begin
					tmo_q <= tmo_q + TW'(1);
					if (prim_done)
						fetch_q <= redriver_cfg_pkg::F_DONE;
					else if (fetch_abort)
						fetch_q <= redriver_cfg_pkg::F_FAIL;
				end
				default: fetch_q <= fetch_q;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN)
			done_n_q <= 1'b1;
		else if (CE && fetch_q == redriver_cfg_pkg::F_RUN && prim_done)
			done_n_q <= 1'b0;
	end

	eeprom_fetch_primary #(
		.NUM_BYTES (NUM_CH),
		.IW        (IW)
	) u_primary (
		.clk        (CLK_SYS),
		.rst_n      (RESETN),
		.ce         (CE),
		.start      (fetch_start),
		.abort      (fetch_abort),
		.scl_i      (SCL_I),
		.sda_i      (SDA_I),
		.scl_oe     (SCL_OE),
		.sda_oe     (SDA_OE),
		.byte_valid (byte_valid),
		.byte_idx   (byte_idx),
		.byte_data  (byte_data),
		.done       (prim_done),
		.busy       ()
	);

	////////////////////////////////////////////////////////////////////////////
	// Per-channel registers; a secondary write beats an EEPROM byte in the same cycle
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			for (int i = 0; i < NUM_CH; i++)
				cfg_q[i] <= `CFG_RST;
		end else if (CE) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (sec_wr_ok && ch_hit(SEC_ADDR, i))
					cfg_q[i] <= SEC_WDATA;
				else if (byte_valid && fetch_q == redriver_cfg_pkg::F_RUN && ch_hit(byte_idx, i))
					cfg_q[i] <= byte_data;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN)
			rdata_q <= '0;
		else if (CE)
			rdata_q <= (int'(SEC_ADDR) < NUM_CH) ? cfg_q[SEC_ADDR] : '0;
	end

	// Pin mode drives every channel from the straps, otherwise from the registers
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			for (int i = 0; i < NUM_CH; i++) begin
				eq_q[i*`EQ_W +: `EQ_W]       <= `EQ_W'(`CFG_RST >> `EQ_LSB);
				gain_q[i*`GAIN_W +: `GAIN_W] <= `GAIN_W'(`CFG_RST >> `GAIN_LSB);
			end
		end else if (CE) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (is_pin) begin
					eq_q[i*`EQ_W +: `EQ_W]       <= STRAP_EQ;
					gain_q[i*`GAIN_W +: `GAIN_W] <= STRAP_GAIN;
				end else begin
					eq_q[i*`EQ_W +: `EQ_W]       <= cfg_q[i][`EQ_LSB +: `EQ_W];
					gain_q[i*`GAIN_W +: `GAIN_W] <= cfg_q[i][`GAIN_LSB +: `GAIN_W];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	sequence s_load_req;
		CE && fetch_q == redriver_cfg_pkg::F_IDLE && is_eeprom && !READ_EN_N;
	endsequence

	sequence s_load_expire;
		CE && fetch_q == redriver_cfg_pkg::F_RUN && tmo_q == TW'(T_EEPROM_CYC - 1) && !prim_done;
	endsequence

	a_pin_straps: assert property (
		CE && is_pin |=> CH_EQ == {NUM_CH{$past(STRAP_EQ)}} && CH_GAIN == {NUM_CH{$past(STRAP_GAIN)}})
		else $error("pin mode outputs do not follow straps");
	a_fetch_launch: assert property (s_load_req |=> fetch_q == redriver_cfg_pkg::F_RUN)
		else $error("EEPROM load did not start");
	a_done_cause: assert property (
		$fell(CONFIG_LOAD_COMPLETE_N) |-> $past(prim_done && fetch_q == redriver_cfg_pkg::F_RUN))
		else $error("load complete fell without a finished read");
	a_sec_write: assert property (
		CE && sec_wr_ok && SEC_ADDR == '0 |=> cfg_q[0] == $past(SEC_WDATA))
		else $error("secondary write not stored");
	a_chan_isolate: assert property (
		CE && sec_wr_ok && SEC_ADDR == '0 && !byte_valid |=> $stable(cfg_q[NUM_CH-1]))
		else $error("write to one channel disturbed another");
	a_load_bound: assert property (s_load_expire |=> fetch_q == redriver_cfg_pkg::F_FAIL)
		else $error("load time limit not enforced");
	a_por_gate: assert property ($rose(SEC_READY) |-> $past(por_cnt_q) == PW'(T_POR_CYC - 1)
		|| $past(por_done_q))
		else $error("secondary opened before power-on delay");
	a_done_mode: assert property (!CONFIG_LOAD_COMPLETE_N |-> is_eeprom)
		else $error("load complete low outside EEPROM mode");
	a_byte_store: assert property (
		CE && byte_valid && fetch_q == redriver_cfg_pkg::F_RUN && !(sec_wr_ok && SEC_ADDR == byte_idx)
		|=> cfg_q[$past(byte_idx)] == $past(byte_data))
		else $error("EEPROM byte not stored in its channel");
endmodule : redriver_config_mode_loader
`default_nettype wire

// *** rtl/redriver_cfg_params.svh ***
// Contract
// - Each channel has its own configuration register, and a write to one never changes another.
// - In pin mode every channel setting comes straight from the sampled strap levels.
// - In EEPROM mode the block is bus primary and reads its configuration from a serial EEPROM.
// - After a successful EEPROM read the load-complete output is driven low.
// - In EEPROM mode the secondary register port stays usable before, during and after the read.
// - The EEPROM load ends within 7.5 ms of the read enable going low, flagged as complete or as failed.
// - The first secondary access is possible within 50 ms of power up and not before.
`ifndef REDRIVER_CFG_PARAMS_SVH
`define REDRIVER_CFG_PARAMS_SVH

`define CLK_FREQ_KHZ  25000
`define SCL_FREQ_KHZ  303
`define SCL_QTR_CYC   (`CLK_FREQ_KHZ / (`SCL_FREQ_KHZ * 4))
`define T_EEPROM_MS   7.5
`define T_POR_MS      50
`define EE_DEV_ADDR   7'h50
`define EE_WORD_ADDR  8'h00
`define NUM_CH        4
`define CFG_W         8
`define EQ_W          5
`define EQ_LSB        0
`define GAIN_W        3
`define GAIN_LSB      5
`define CFG_RST       8'ha0
`define ACK_BIT       4'h8

`endif

// *** rtl/redriver_cfg_pkg.sv ***
`default_nettype none
package redriver_cfg_pkg;
	typedef enum logic [1:0] {
		MODE_PIN       = 2'b00,
		MODE_EEPROM    = 2'b01,
		MODE_SECONDARY = 2'b10,
		MODE_SEC_ALT   = 2'b11
	} cfg_mode_t;

	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_RUN  = 2'b01,
		F_DONE = 2'b10,
		F_FAIL = 2'b11
	} fetch_state_t;

	typedef enum logic [2:0] {
		P_IDLE  = 3'b000,
		P_START = 3'b001,
		P_TX    = 3'b010,
		P_RX    = 3'b011,
		P_STOP  = 3'b100,
		P_WAIT  = 3'b101
	} prim_state_t;
endpackage : redriver_cfg_pkg
`default_nettype wire

// *** rtl/eeprom_fetch_primary.sv ***
`include "redriver_cfg_params.svh"
`default_nettype none
module eeprom_fetch_primary #(
	parameter int       NUM_BYTES = `NUM_CH,
	parameter logic [6:0] DEV_ADDR = `EE_DEV_ADDR,
	parameter int       QTR_CYC   = `SCL_QTR_CYC,
	parameter int       IW        = (NUM_BYTES > 1) ? $clog2(NUM_BYTES) : 1
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          start,
	input  wire logic          abort,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output logic               scl_oe,
	output logic               sda_oe,
	output logic               byte_valid,
	output logic [IW-1:0]      byte_idx,
	output logic [7:0]         byte_data,
	output logic               done,
	output logic               busy
);
	localparam int CW = $clog2(QTR_CYC + 1);

	redriver_cfg_pkg::prim_state_t state_q;
	logic [1:0]    phase_q;
	logic [CW-1:0] cnt_q;
	logic [3:0]    bit_q;
	logic [7:0]    shift_q;
	logic [1:0]    step_q;
	logic [IW-1:0] idx_q;
	logic          rep_q;
	logic          nack_q;
	logic          retry_q;
	logic          tick;
	logic          hold;
	logic          last;

	assign busy = (state_q != redriver_cfg_pkg::P_IDLE);
	assign last = (idx_q == IW'(NUM_BYTES - 1));
	assign tick = busy && !hold && (cnt_q == CW'(QTR_CYC - 1));

	// Clock stretching holds the bit timer; the backoff also waits for an idle bus
	always_comb begin
		if (state_q == redriver_cfg_pkg::P_WAIT)
			hold = !scl_i || !sda_i;
		else
			hold = !scl_oe && (phase_q == 2'h1 || phase_q == 2'h2) && !scl_i;
	end

	// Open-drain drive: an enable pulls the line low
	always_comb begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		case (state_q)
			redriver_cfg_pkg::P_START: begin
				scl_oe = (phase_q == 2'h0 && rep_q) || phase_q == 2'h3;
				sda_oe = phase_q[1];
			end
			redriver_cfg_pkg::P_TX: begin
				scl_oe = phase_q == 2'h0 || phase_q == 2'h3;
				sda_oe = (bit_q != `ACK_BIT) && !shift_q[7];
			end
			redriver_cfg_pkg::P_RX: begin
				scl_oe = phase_q == 2'h0 || phase_q == 2'h3;
				sda_oe = (bit_q == `ACK_BIT) && !last;
			end
			redriver_cfg_pkg::P_STOP: begin
				scl_oe = phase_q == 2'h0;
				sda_oe = phase_q != 2'h3;
			end
			default: begin
				scl_oe = 1'b0;
				sda_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !busy || tick)
			cnt_q <= '0;
		else if (ce && !hold)
			cnt_q <= cnt_q + CW'(1);
	end

	////////////////////////////////////////////////////////////////////////////
	// Transaction sequencer: write word address, repeated start, read bytes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q    <= redriver_cfg_pkg::P_IDLE;
			phase_q    <= 2'h0;
			bit_q      <= 4'h0;
			shift_q    <= 8'h00;
			step_q     <= 2'h0;
			idx_q      <= '0;
			rep_q      <= 1'b0;
			nack_q     <= 1'b0;
			retry_q    <= 1'b0;
			byte_valid <= 1'b0;
			byte_idx   <= '0;
			byte_data  <= 8'h00;
			done       <= 1'b0;
		end else if (ce) begin
			byte_valid <= 1'b0;
			done       <= 1'b0;
			if (abort) begin
				state_q <= redriver_cfg_pkg::P_IDLE;
			end else if (state_q == redriver_cfg_pkg::P_IDLE) begin
				if (start) begin
					state_q <= redriver_cfg_pkg::P_START;
					phase_q <= 2'h0;
					rep_q   <= 1'b0;
					step_q  <= 2'h0;
					idx_q   <= '0;
				end
			end else if (tick) begin
				phase_q <= phase_q + 2'h1;
				case (state_q)
					redriver_cfg_pkg::P_START: begin
						if (phase_q == 2'h1 && !sda_i) begin
							state_q <= redriver_cfg_pkg::P_WAIT;
							phase_q <= 2'h0;
						end else if (phase_q == 2'h3) begin
							state_q <= redriver_cfg_pkg::P_TX;
							bit_q   <= 4'h0;
							shift_q <= {DEV_ADDR, step_q == 2'h2};
						end
					end
					redriver_cfg_pkg::P_TX: begin
						if (phase_q == 2'h2) begin
							nack_q <= (bit_q == `ACK_BIT) && sda_i;
							// Lost arbitration: another primary holds SDA low
							if (bit_q != `ACK_BIT && shift_q[7] && !sda_i) begin
								state_q <= redriver_cfg_pkg::P_WAIT;
								phase_q <= 2'h0;
							end
						end else if (phase_q == 2'h3) begin
							if (bit_q != `ACK_BIT) begin
								shift_q <= {shift_q[6:0], 1'b0};
								bit_q   <= bit_q + 4'h1;
							end else if (nack_q) begin
								state_q <= redriver_cfg_pkg::P_STOP;
								retry_q <= 1'b1;
							end else if (step_q == 2'h0) begin
								shift_q <= `EE_WORD_ADDR;
								bit_q   <= 4'h0;
								step_q  <= 2'h1;
							end else if (step_q == 2'h1) begin
								state_q <= redriver_cfg_pkg::P_START;
								rep_q   <= 1'b1;
								step_q  <= 2'h2;
							end else begin
								state_q <= redriver_cfg_pkg::P_RX;
								bit_q   <= 4'h0;
								step_q  <= 2'h3;
							end
						end
					end
					redriver_cfg_pkg::P_RX: begin
						if (phase_q == 2'h2 && bit_q != `ACK_BIT) begin
							shift_q <= {shift_q[6:0], sda_i};
						end else if (phase_q == 2'h3) begin
							if (bit_q != `ACK_BIT) begin
								bit_q <= bit_q + 4'h1;
							end else begin
								byte_valid <= 1'b1;
								byte_idx   <= idx_q;
								byte_data  <= shift_q;
								idx_q      <= idx_q + IW'(1);
								bit_q      <= 4'h0;
								if (last) begin
									state_q <= redriver_cfg_pkg::P_STOP;
									retry_q <= 1'b0;
								end
							end
						end
					end
					redriver_cfg_pkg::P_STOP: begin
						if (phase_q == 2'h3) begin
							state_q <= retry_q ? redriver_cfg_pkg::P_WAIT
							                   : redriver_cfg_pkg::P_IDLE;
							done    <= !retry_q;
						end
					end
					default: begin
						if (phase_q == 2'h3) begin
							state_q <= redriver_cfg_pkg::P_START;
							rep_q   <= 1'b0;
							step_q  <= 2'h0;
							idx_q   <= '0;
						end
					end
				endcase
			end
		end
	end

	a_last_nack: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == redriver_cfg_pkg::P_RX && bit_q == `ACK_BIT) |-> (sda_oe == !last))
		else $error("read acknowledge bit wrong for byte position");
endmodule : eeprom_fetch_primary
`default_nettype wire

// *** verification/eeprom_model.sv ***
`default_nettype none
// Behavioural serial EEPROM at 7'h50; can refuse its address and stretch the clock after acks
module eeprom_model (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic refuse,
	input  wire logic stretch,
	output logic      scl_pull,
	output logic      sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4] = '{8'h13, 8'h45, 8'hc7, 8'hfe};
	logic [7:0] sh;
	logic [3:0] cnt;
	logic [1:0] ptr;
	logic [1:0] st;
	logic       act;
	logic       rd;
	logic       skip;
	initial begin
		{scl_pull, sda_pull, act, rd, skip, cnt, ptr, st, sh} = '0;
	end
	////////////////////////////////////////
	always @(negedge sda) if (scl === 1'b1) begin
		{act, rd, skip, cnt, st} = {3'b101, 4'h0, 2'd0};
		sda_pull = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		act = 1'b0;
		sda_pull = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda};
		else if (st == 2'd2 && sda) act = 1'b0; // Primary NACK ends the read
	end
	always @(negedge scl) if (act) begin
		if (skip) begin
			skip = 1'b0;
		end else begin
			cnt = cnt + 4'h1;
			if (cnt == 4'h8) begin
				if (st == 2'd2) sda_pull = 1'b0;
				else if (st == 2'd1) begin
					ptr = sh[1:0];
					sda_pull = 1'b1;
				end else if (sh[7:1] == 7'h50 && !refuse) begin
					rd = sh[0];
					sda_pull = 1'b1;
				end else begin
					act = 1'b0;
				end
			end else if (cnt == 4'h9) begin
				cnt = 4'h0;
				sda_pull = 1'b0;
				if (st == 2'd2) ptr = ptr + 2'h1;
				else if (st == 2'd0) st = rd ? 2'd2 : 2'd1;
				if (st == 2'd2) sda_pull = !mem[ptr][7];
				if (stretch) begin
					scl_pull = 1'b1;
					#2000 scl_pull = 1'b0;
				end
			end else if (st == 2'd2) begin
				sda_pull = !mem[ptr][7 - cnt];
			end
		end
	end
endmodule : eeprom_model
`default_nettype wire

// *** verification/test_redriver_config_mode_loader.sv ***
`default_nettype none
module test_redriver_config_mode_loader;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_SYS    = 1'b0;
	logic        RESETN     = 1'b0;
	logic        CE         = 1'b1;
	logic [1:0]  MODE_STRAP = 2'b00;
	logic [4:0]  STRAP_EQ   = 5'h13;
	logic [2:0]  STRAP_GAIN = 3'h3;
	logic        READ_EN_N  = 1'b1;
	logic        SEC_WR_EN  = 1'b0;
	logic [1:0]  SEC_ADDR   = 2'h0;
	logic [7:0]  SEC_WDATA  = 8'h00;
	logic        refuse     = 1'b0;
	logic        stretch    = 1'b0;
	logic        SCL_O, SCL_OE, SDA_O, SDA_OE, scl_pull, sda_pull, SEC_READY, done_n, fail;
	logic [7:0]  SEC_RDATA;
	logic [19:0] CH_EQ;
	logic [11:0] CH_GAIN;
	wire         scl_w = !(SCL_OE || scl_pull);
	wire         sda_w = !(SDA_OE || sda_pull);
	int          miscompares = 0;
	int          n_tests     = 0;
	int          n;
	logic [7:0]  ee [4] = '{8'h13, 8'h45, 8'hc7, 8'hfe};
	logic [7:0]  sv [4] = '{8'h11, 8'h52, 8'h93, 8'hf4};

	always #20 CLK_SYS = ~CLK_SYS;

	redriver_config_mode_loader #(.T_EEPROM_CYC(8000), .T_POR_CYC(20)) dut (
		.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CE(CE), .MODE_STRAP(MODE_STRAP),
		.STRAP_EQ(STRAP_EQ), .STRAP_GAIN(STRAP_GAIN), .READ_EN_N(READ_EN_N),
		.SCL_I(scl_w), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(SDA_O),
		.SDA_OE(SDA_OE), .SEC_WR_EN(SEC_WR_EN), .SEC_ADDR(SEC_ADDR), .SEC_WDATA(SEC_WDATA),
		.SEC_RDATA(SEC_RDATA), .SEC_READY(SEC_READY), .CH_EQ(CH_EQ), .CH_GAIN(CH_GAIN),
		.CONFIG_LOAD_COMPLETE_N(done_n), .EEPROM_LOAD_FAIL(fail));

	eeprom_model ee_mdl (.scl(scl_w), .sda(sda_w), .refuse(refuse), .stretch(stretch),
		.scl_pull(scl_pull), .sda_pull(sda_pull));
	////////////////////////////////////////
	task automatic tally_and_finish;
		if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_ch(input int i, input logic [7:0] b);
		chk(CH_EQ[5*i+:5], b[4:0]);
		chk(CH_GAIN[3*i+:3], b[7:5]);
	endtask : chk_ch

	task automatic do_reset(input logic [1:0] mode);
		@(negedge CLK_SYS);
		RESETN = 1'b0;
		MODE_STRAP = mode;
		READ_EN_N = 1'b1;
		repeat (3) @(negedge CLK_SYS);
		chk({done_n, fail, SEC_READY, SCL_OE, SDA_OE}, 5'b10000);
		chk({CH_EQ, CH_GAIN}, {20'h0, 12'hb6d});
		RESETN = 1'b1;
	endtask : do_reset

	// Leaves the strobe high so that writes can follow back to back
	task automatic sec_wr(input logic [1:0] a, input logic [7:0] d);
		SEC_WR_EN = 1'b1;
		SEC_ADDR = a;
		SEC_WDATA = d;
		@(negedge CLK_SYS);
	endtask : sec_wr

	task automatic wait_done(input int lim);
		n = 0;
		while (done_n !== 1'b0 && fail !== 1'b1 && n < lim) begin
			@(negedge CLK_SYS);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			$display("FAIL %0t load never finished", $time);
			tally_and_finish();
		end
	endtask : wait_done
	////////////////////////////////////////
	task automatic t_pin;
		do_reset(2'b00);
		READ_EN_N = 1'b0;
		repeat (30) @(negedge CLK_SYS);
		chk(SEC_READY, 1'b0);
		sec_wr(2'h1, 8'h3f);
		SEC_WR_EN = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		for (int i = 0; i < 4; i++) chk_ch(i, 8'h73);
		chk({done_n, SCL_OE, SDA_OE}, 3'b100);
	endtask : t_pin

	task automatic t_sec(input logic [1:0] mode);
		do_reset(mode);
		READ_EN_N = 1'b0;
		repeat (19) @(negedge CLK_SYS);
		chk(SEC_READY, 1'b0);
		@(negedge CLK_SYS);
		chk(SEC_READY, 1'b1);
		for (int i = 0; i < 4; i++) sec_wr(2'(i), sv[i]);
		SEC_WR_EN = 1'b0;
		SEC_ADDR = 2'h2;
		repeat (3) @(negedge CLK_SYS);
		for (int i = 0; i < 4; i++) chk_ch(i, sv[i]);
		chk(SEC_RDATA, 8'h93);
		sec_wr(2'h1, 8'h3f);
		SEC_WR_EN = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		for (int i = 0; i < 4; i++) chk_ch(i, (i == 1) ? 8'h3f : sv[i]);
		chk({done_n, SCL_OE, SDA_OE}, 3'b100);
		// A write while the clock enable is low must leave the addressed channel 3 register alone
		CE = 1'b0;
		sec_wr(2'h3, 8'h00);
		SEC_WR_EN = 1'b0;
		CE = 1'b1;
		repeat (3) @(negedge CLK_SYS);
		chk_ch(3, sv[3]);
	endtask : t_sec

	task automatic t_load;
		stretch = 1'b1;
		do_reset(2'b01);
		READ_EN_N = 1'b0;
		repeat (25) @(negedge CLK_SYS);
		chk({SEC_READY, done_n}, 2'b11);
		// Secondary write in the middle of the load; the later EEPROM byte replaces it
		sec_wr(2'h0, 8'h77);
		SEC_WR_EN = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		chk_ch(0, 8'h77);
		wait_done(8000);
		chk({done_n, fail}, 2'b00);
		for (int i = 0; i < 4; i++) chk_ch(i, ee[i]);
		sec_wr(2'h2, 8'h5a);
		SEC_WR_EN = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		for (int i = 0; i < 4; i++) chk_ch(i, (i == 2) ? 8'h5a : ee[i]);
		stretch = 1'b0;
	endtask : t_load

	task automatic t_fail;
		refuse = 1'b1;
		do_reset(2'b01);
		READ_EN_N = 1'b0;
		wait_done(8100);
		chk({fail, done_n}, 2'b11);
		chk(n >= 7990 && n <= 8010, 1'b1);
		refuse = 1'b0;
	endtask : t_fail

	initial begin
		t_pin();
		t_sec(2'b10);
		t_sec(2'b11);
		t_load();
		t_fail();
		tally_and_finish();
	end
endmodule : test_redriver_config_mode_loader
`default_nettype wire
